/* core/csag_pkg.sv */
// shared constants for the cascade sync and address gating block
package csag_pkg;
  localparam int CSAG_AW = 4;
  // register byte offsets
  localparam logic [CSAG_AW-1:0] CSAG_OFS_CTRL = 4'h0;
  localparam logic [CSAG_AW-1:0] CSAG_OFS_STAT = 4'h4;
  localparam logic [CSAG_AW-1:0] CSAG_OFS_PTR = 4'h8;
  localparam logic [CSAG_AW-1:0] CSAG_OFS_RDAT = 4'hC;
  // control register fields
  localparam int CSAG_CTRL_DEVADR_LSB = 0;
  localparam int CSAG_CTRL_COE_BIT = 2;
  localparam int CSAG_CTRL_DISP_BIT = 3;
  localparam logic [31:0] CSAG_CTRL_RST = 32'h0000_0000;
  // display memory geometry
  localparam int CSAG_PTR_W = 7;
  localparam logic [CSAG_PTR_W-1:0] CSAG_PTR_LAST = 7'h65;
  localparam logic [CSAG_PTR_W-1:0] CSAG_PTR_RST = 7'h00;
  // internal oscillator clock divider, 50 MHz down to a cascade clock
  localparam int CSAG_CLK_HZ = 50000000;
  localparam int CSAG_CASC_HZ = 1000000;
  localparam int CSAG_CASC_HALF = CSAG_CLK_HZ / (2 * CSAG_CASC_HZ);
  localparam int CSAG_DIV_W = 6;
  // frame sync: last frame counter value, one less than the cascade clock ticks per frame
  localparam logic [7:0] CSAG_FRAME_TICKS = 8'h3F;
  localparam logic [1:0] CSAG_MASTER_ADR = 2'h0;
  localparam logic [1:0] CSAG_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSAG_RESP_SLVERR = 2'h2;
endpackage

/* core/csag_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module csag_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // csag_sync2

/* core/csag_clkdiv.sv */
// divider making the internal cascade clock and its rising-edge tick
`timescale 1ns/1ns
module csag_clkdiv
  import csag_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic clk_lvl,
  output logic tick
);
  logic [CSAG_DIV_W-1:0] cnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      clk_lvl <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run) begin
        cnt_r <= '0;
        clk_lvl <= 1'b0;
      end else if (cnt_r == CSAG_DIV_W'(CSAG_CASC_HALF - 1)) begin
        cnt_r <= '0;
        clk_lvl <= ~clk_lvl;
        tick <= ~clk_lvl;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // csag_clkdiv

/* core/csag_top.sv */
// cascade clock, frame sync and device address gating with AXI4-Lite registers
// Operation
// - both cascade sync lines are bidirectional: drive as source, receive otherwise.
// - frame sync runs automatically after reset with no host command.
// - drive internal clock out when address 00, select low, clock output enable set.
// - select high takes the clock from the cascade clock pin.
// - cascade clock output stops while display is disabled.
// - external-clock mode: all devices run from common clock pin, select high.
// - display data stored only when device address register equals address pins.
// - on mismatch the write is dropped but the data pointer still advances.
// - status or temperature readout returned only on address match.
// - on read mismatch the serial data output stays high impedance.
// - two address pins give identity: 0 master, 1 to 3 slaves.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module csag_top
  import csag_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [csag_pkg::CSAG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [csag_pkg::CSAG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_address_bit_low,
  input wire logic hw_address_bit_high,
  input wire logic oscillator_source_select,
  input wire logic casc_clk_in,
  output logic casc_clk_out,
  output logic casc_clk_oe_n,
  input wire logic cascade_sync_line_a_in,
  output logic cascade_sync_line_a_out,
  output logic cascade_sync_line_a_oe_n,
  input wire logic cascade_sync_line_b_in,
  output logic cascade_sync_line_b_out,
  output logic cascade_sync_line_b_oe_n,
  input wire logic [31:0] readout_data,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic mem_we,
  output logic [csag_pkg::CSAG_PTR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [csag_pkg::CSAG_PTR_W-1:0] data_ptr
);
  import csag_pkg::*;

  // pin inputs, all synchronised before use
  logic [4:0] pins_s;
  csag_sync2 #(.W(5)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({hw_address_bit_high, hw_address_bit_low, oscillator_source_select,
        cascade_sync_line_a_in, cascade_sync_line_b_in}),
    .q(pins_s)
  );
  logic [1:0] hw_adr;
  logic osc_ext;
  logic sync_a_s;
  logic sync_b_s;
  assign hw_adr = pins_s[4:3];
  assign osc_ext = pins_s[2];
  assign sync_a_s = pins_s[1];
  assign sync_b_s = pins_s[0];

  logic [1:0] csync_s;
  csag_sync2 #(.W(1)) u_csync (
    .clock(clock),
    .rst_n(rst_n),
    .d(casc_clk_in),
    .q(csync_s[0])
  );
  logic casc_prev_r;
  assign csync_s[1] = casc_prev_r;

  // control register
  logic [31:0] ctrl_r;
  logic [1:0] dev_adr;
  logic clock_output_enable;
  logic disp_en;
  assign dev_adr = ctrl_r[CSAG_CTRL_DEVADR_LSB +: 2];
  assign clock_output_enable = ctrl_r[CSAG_CTRL_COE_BIT];
  assign disp_en = ctrl_r[CSAG_CTRL_DISP_BIT];
  logic adr_match;
  assign adr_match = (dev_adr == hw_adr);

  // clock source: internal divider or external pin
  logic is_master;
  logic drive_clk;
  assign is_master = (hw_adr == CSAG_MASTER_ADR);
  assign drive_clk = is_master && !osc_ext && clock_output_enable && disp_en;
  logic int_lvl;
  logic int_tick;
  csag_clkdiv u_div (
    .clock(clock),
    .rst_n(rst_n),
    .run(!osc_ext),
    .clk_lvl(int_lvl),
    .tick(int_tick)
  );
  logic ext_tick;
  assign ext_tick = csync_s[0] && !csync_s[1];
  logic tick;
  assign tick = osc_ext ? ext_tick : int_tick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      casc_prev_r <= 1'b0;
    end else begin
      casc_prev_r <= csync_s[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      casc_clk_out <= 1'b0;
      casc_clk_oe_n <= 1'b1;
    end else begin
      casc_clk_out <= drive_clk & int_lvl;
      casc_clk_oe_n <= !drive_clk;
    end
  end

  // frame sync: master drives, slaves align to the received pulse.
  // no host command is needed, the counter starts from reset release.
  logic [7:0] frame_r;
  logic sync_rise;
  logic sync_a_prev_r;
  assign sync_rise = sync_a_s && !sync_a_prev_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= '0;
      sync_a_prev_r <= 1'b0;
    end else begin
      sync_a_prev_r <= sync_a_s;
      if (!is_master && sync_rise) begin
        frame_r <= '0;
      end else if (tick) begin
        frame_r <= (frame_r == CSAG_FRAME_TICKS) ? 8'h00 : frame_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cascade_sync_line_a_out <= 1'b0;
      cascade_sync_line_a_oe_n <= 1'b1;
      cascade_sync_line_b_out <= 1'b0;
      cascade_sync_line_b_oe_n <= 1'b1;
    end else begin
      // line a carries the frame start, line b the half frame; a slave only listens
      cascade_sync_line_a_out <= (frame_r == 8'h00);
      cascade_sync_line_a_oe_n <= !is_master;
      cascade_sync_line_b_out <= frame_r[7] ^ frame_r[5];
      cascade_sync_line_b_oe_n <= !is_master;
    end
  end

  // AXI4-Lite write path
  logic aw_hold_r;
  logic w_hold_r;
  logic [CSAG_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CSAG_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == CSAG_OFS_CTRL || aw_addr_r == CSAG_OFS_RDAT ||
                        aw_addr_r == CSAG_OFS_PTR) ? CSAG_RESP_OKAY : CSAG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CSAG_CTRL_RST;
    end else if (do_write && aw_addr_r == CSAG_OFS_CTRL && w_strb_r[0]) begin
      ctrl_r <= {24'h0, 4'h0, w_data_r[3:0]};
    end
  end

  // display data write: a byte to the data offset. every device sees it,
  // so all pointers stay aligned whether or not this one stores it.
  logic data_wr;
  assign data_wr = do_write && aw_addr_r == CSAG_OFS_RDAT && w_strb_r[0];
  logic ptr_wr;
  assign ptr_wr = do_write && aw_addr_r == CSAG_OFS_PTR && w_strb_r[0];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_ptr <= CSAG_PTR_RST;
    end else if (ptr_wr) begin
      data_ptr <= (w_data_r[6:0] > CSAG_PTR_LAST) ? CSAG_PTR_RST : w_data_r[6:0];
    end else if (data_wr) begin
      data_ptr <= (data_ptr == CSAG_PTR_LAST) ? CSAG_PTR_RST : data_ptr + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else begin
      // address pins assumed steady during the access
      mem_we <= data_wr && adr_match;
      mem_addr <= data_ptr;
      mem_wdata <= w_data_r[7:0];
    end
  end

  // AXI4-Lite read path
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      CSAG_OFS_CTRL: rd_mux = ctrl_r;
      CSAG_OFS_STAT: rd_mux = {16'h0, frame_r, 3'h0, drive_clk, osc_ext, adr_match, hw_adr};
      CSAG_OFS_PTR: rd_mux = {25'h0, data_ptr};
      CSAG_OFS_RDAT: rd_mux = adr_match ? readout_data : 32'h0000_0000;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  logic rd_known;
  assign rd_known = (s_axi_araddr == CSAG_OFS_CTRL) || (s_axi_araddr == CSAG_OFS_STAT) ||
                    (s_axi_araddr == CSAG_OFS_PTR) || (s_axi_araddr == CSAG_OFS_RDAT);
  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= CSAG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? CSAG_RESP_OKAY : CSAG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // serial readout pin: a readout shifts bit 0 of the fetched word out only
  // when addressed; otherwise the pin is released so it cannot fight a peer
  logic rd_readout;
  assign rd_readout = rd_take && s_axi_araddr == CSAG_OFS_RDAT;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdo_out <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (rd_readout) begin
      sdo_out <= adr_match & readout_data[0];
      sdo_oe_n <= !adr_match;
    end else begin
      sdo_oe_n <= 1'b1;
      sdo_out <= 1'b0;
    end
  end

  a_clk_drive_cond: assert property (@(posedge clock) disable iff (!rst_n)
    !casc_clk_oe_n |-> $past(is_master && !osc_ext && clock_output_enable && disp_en))
    else $error("cascade clock driven without its conditions");
  a_clk_off_disabled: assert property (@(posedge clock) disable iff (!rst_n)
    !disp_en ##1 !disp_en |-> casc_clk_oe_n)
    else $error("cascade clock driven while display disabled");
  a_store_match: assert property (@(posedge clock) disable iff (!rst_n)
    mem_we |-> $past(data_wr && adr_match))
    else $error("display write without address match");
  a_ptr_advance: assert property (@(posedge clock) disable iff (!rst_n)
    data_wr && !adr_match && data_ptr != CSAG_PTR_LAST |=> data_ptr == $past(data_ptr) + 7'h01)
    else $error("pointer did not advance on mismatch");
  a_ptr_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    data_wr && data_ptr == CSAG_PTR_LAST |=> data_ptr == CSAG_PTR_RST)
    else $error("pointer did not wrap");
  a_read_gate: assert property (@(posedge clock) disable iff (!rst_n)
    rd_take && s_axi_araddr == CSAG_OFS_RDAT && !adr_match |=> s_axi_rdata == 32'h0)
    else $error("readout returned while not addressed");
  a_sdo_tristate: assert property (@(posedge clock) disable iff (!rst_n)
    rd_readout && !adr_match |=> sdo_oe_n)
    else $error("serial output driven while not addressed");
  a_sync_slave_in: assert property (@(posedge clock) disable iff (!rst_n)
    !is_master ##1 !is_master |-> cascade_sync_line_a_oe_n && cascade_sync_line_b_oe_n)
    else $error("slave drives a sync line");
  a_ext_tick_src: assert property (@(posedge clock) disable iff (!rst_n)
    osc_ext && tick |-> csync_s[0] && !$past(csync_s[0]))
    else $error("external mode ticks without a clock pin edge");
endmodule // csag_top

/* sim/csag_peer.sv */
// peer driver model: drives the shared cascade clock and sync lines as cascade master
`timescale 1ns/1ns
module csag_peer (
  input wire logic run,
  output logic clk_o,
  output logic sync_a_o,
  output logic sync_b_o
);
  logic [5:0] tick_r;
  logic was_r;
  // one common 1 MHz clock on the pin, standing still low while run is low
  initial begin
    clk_o = 1'h0;
    sync_a_o = 1'h0;
    sync_b_o = 1'h0;
    tick_r = 6'h00;
    was_r = 1'h0;
    #7;
    forever begin
      #500;
      if (run) begin
        clk_o = ~clk_o;
        if (clk_o) begin
          sync_a_o = (tick_r == 6'h00); // frame start marker
          sync_b_o = tick_r[5];
          tick_r = tick_r + 6'h01;
        end
      end else begin
        clk_o = 1'h0;
        tick_r = 6'h00;
        // released lines must not keep the last level, or a stale high would look driven
        if (was_r) begin
          sync_a_o = ~sync_a_o;
          sync_b_o = ~sync_b_o;
        end
      end
      was_r = run;
    end
  end
endmodule // csag_peer

/* sim/tb_cascade_sync_address_gating.sv */
// testbench for the cascade sync and address gating block
`timescale 1ns/1ns
module tb_cascade_sync_address_gating;
  import csag_pkg::*;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, osc, prun;
  logic awready, wready, bvalid, arready, rvalid, cko, cko_oe_n, sao, sao_oe_n;
  logic sbo, sbo_oe_n, sdo, sdo_oe_n, mem_we, pclk, psa, psb, sdo_bit;
  logic [CSAG_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, readout, d, c1, c2;
  logic [1:0] bresp, rresp, pins, r;
  logic [CSAG_PTR_W-1:0] mem_addr, ptr, we_addr;
  logic [7:0] mem_wdata, we_data;
  int num_errors, cmp_count, we_cnt, sdo_cnt, n0, sa_cnt;
  wire casc = cko_oe_n ? pclk : cko;
  wire sync_a = sao_oe_n ? psa : sao;
  wire sync_b = sbo_oe_n ? psb : sbo;
  csag_top DUT (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hw_address_bit_low(pins[0]), .hw_address_bit_high(pins[1]),
    .oscillator_source_select(osc), .casc_clk_in(casc), .casc_clk_out(cko),
    .casc_clk_oe_n(cko_oe_n), .cascade_sync_line_a_in(sync_a), .cascade_sync_line_a_out(sao),
    .cascade_sync_line_a_oe_n(sao_oe_n), .cascade_sync_line_b_in(sync_b),
    .cascade_sync_line_b_out(sbo), .cascade_sync_line_b_oe_n(sbo_oe_n),
    .readout_data(readout), .sdo_out(sdo), .sdo_oe_n(sdo_oe_n), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .data_ptr(ptr));
  csag_peer peer (.run(prun), .clk_o(pclk), .sync_a_o(psa), .sync_b_o(psb));
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (mem_we === 1'h1) begin
      we_cnt++;
      we_addr = mem_addr;
      we_data = mem_wdata;
    end
    if (sdo_oe_n === 1'h0) begin
      sdo_cnt++;
      sdo_bit = sdo;
    end
    if (sao_oe_n === 1'h0 && sao === 1'h1) sa_cnt++;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [CSAG_AW-1:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clock);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [CSAG_AW-1:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clock);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask
  function automatic logic [31:0] cv(input logic [1:0] adr, input logic clock_output_enable, input logic en);
    cv = 32'h0;
    cv[CSAG_CTRL_DEVADR_LSB +: 2] = adr;
    cv[CSAG_CTRL_COE_BIT] = clock_output_enable;
    cv[CSAG_CTRL_DISP_BIT] = en;
  endfunction
  // pins settle through the synchroniser before any access and then stay put
  task automatic set_pins(input logic [1:0] p, input logic o);
    @(posedge clock);
    pins <= p;
    osc <= o;
    cyc(6);
  endtask
  task automatic t_regs;
    rd(CSAG_OFS_CTRL);
    chk("ctrl reset", d, CSAG_CTRL_RST);
    rd(4'h2);
    chk("unmapped rresp", r, CSAG_RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    wr(4'h6, 32'h0);
    chk("unmapped bresp", r, CSAG_RESP_SLVERR);
    chk("sync a frame start", sa_cnt != 0, 1'h1);
    rd(CSAG_OFS_STAT);
    chk("stat addr match", d[2:0], 3'h4);
    chk("sync a master drive", sao_oe_n, 1'h0);
    chk("sync b master drive", sbo_oe_n, 1'h0);
    chk("clk idle", cko_oe_n, 1'h1);
  endtask
  task automatic t_write_gate;
    set_pins(2'h2, 1'h0);
    wr(CSAG_OFS_CTRL, cv(2'h2, 1'h0, 1'h0));
    wr(CSAG_OFS_PTR, 32'h64);
    n0 = we_cnt;
    wr(CSAG_OFS_RDAT, 32'h5A);
    chk("data bresp", r, CSAG_RESP_OKAY);
    cyc(3);
    chk("we count", we_cnt, n0 + 1);
    chk("we addr", we_addr, 7'h64);
    chk("we data", we_data, 8'h5A);
    wr(CSAG_OFS_RDAT, 32'hC3);
    cyc(3);
    chk("we addr last", we_addr, CSAG_PTR_LAST);
    chk("ptr wrap", ptr, CSAG_PTR_RST);
    wr(CSAG_OFS_CTRL, cv(2'h1, 1'h0, 1'h0));
    wr(CSAG_OFS_PTR, 32'h65);
    n0 = we_cnt;
    wr(CSAG_OFS_RDAT, 32'h77);
    wr(CSAG_OFS_RDAT, 32'h78);
    cyc(3);
    chk("we blocked", we_cnt, n0);
    chk("ptr advance", ptr, 7'h01);
  endtask
  task automatic t_read_gate;
    readout <= 32'hA5C3_1E0F;
    set_pins(2'h3, 1'h0);
    wr(CSAG_OFS_CTRL, cv(2'h3, 1'h0, 1'h0));
    n0 = sdo_cnt;
    rd(CSAG_OFS_RDAT);
    cyc(2);
    chk("readout", d, 32'hA5C3_1E0F);
    chk("readout rresp", r, CSAG_RESP_OKAY);
    chk("sdo driven", sdo_cnt, n0 + 1);
    chk("sdo bit", sdo_bit, 1'h1);
    wr(CSAG_OFS_CTRL, cv(2'h0, 1'h0, 1'h0));
    n0 = sdo_cnt;
    rd(CSAG_OFS_RDAT);
    cyc(2);
    chk("readout gated", d, 32'h0);
    chk("sdo released", sdo_cnt, n0);
  endtask
  task automatic t_clk_drive;
    int n;
    logic p;
    set_pins(2'h0, 1'h0);
    wr(CSAG_OFS_CTRL, cv(2'h0, 1'h1, 1'h1));
    cyc(10);
    chk("clk drive", cko_oe_n, 1'h0);
    n = 0;
    p = cko;
    for (int i = 0; i < 100; i++) begin
      @(posedge clock);
      if (cko !== p) n++;
      p = cko;
    end
    chk("clk edges", n, 100 / CSAG_CASC_HALF);
    // one write carries the display switch to every device at once
    wr(CSAG_OFS_CTRL, cv(2'h0, 1'h1, 1'h0));
    cyc(4);
    chk("clk off disabled", cko_oe_n, 1'h1);
    wr(CSAG_OFS_CTRL, cv(2'h0, 1'h1, 1'h1));
    set_pins(2'h1, 1'h0);
    chk("clk off slave", cko_oe_n, 1'h1);
    chk("sync a slave", sao_oe_n, 1'h1);
    set_pins(2'h0, 1'h1);
    chk("clk off ext", cko_oe_n, 1'h1);
  endtask
  task automatic t_ext_clk;
    set_pins(2'h1, 1'h1);
    wr(CSAG_OFS_CTRL, cv(2'h1, 1'h0, 1'h1));
    prun <= 1'h1;
    cyc(600);
    rd(CSAG_OFS_STAT);
    c1 = d;
    chk("stat pins", d[3:0], 4'hD);
    cyc(500);
    rd(CSAG_OFS_STAT);
    chk("frame runs", d[15:8] != c1[15:8], 1'h1);
    prun <= 1'h0;
    cyc(200);
    rd(CSAG_OFS_STAT);
    c2 = d;
    cyc(500);
    rd(CSAG_OFS_STAT);
    chk("frame frozen", d[15:8], c2[15:8]);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("timeout waiting on the design");
    close_out();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, osc, prun} = 8'h00;
    {awaddr, araddr, wdata, readout, pins} = 'h0;
    {num_errors, cmp_count, we_cnt, sdo_cnt, sa_cnt} = {5{32'h0}};
    sdo_bit = 1'h0;
    cyc(3);
    rst_n <= 1'h1;
    cyc(4);
    t_regs();
    t_write_gate();
    t_read_gate();
    t_clk_drive();
    t_ext_clk();
    close_out();
  end
endmodule // tb_cascade_sync_address_gating
